// ---- src/mvcd_top.sv ----
`timescale 1ns/100ps
// Operation
// - latch enabled keeps the change flag set until the source register is read
// - latch disabled makes the flag follow the live detection each sample
// - init mode zero takes the current sample as reference at enable
// - init mode one takes the initial-value registers as reference at enable
// - update mode zero replaces the reference with the sample on each event
// - update mode one keeps the reference on an event
// - both modes set make initial-value writes live reference while enabled
// - enable bit off stops detection; on loads reference from chosen source
// - wake bit decides whether the change flag counts as auto-sleep activity
// - interrupt enable bit gates the change flag onto an interrupt pin
// - routing bit zero selects pin two, one selects pin one
// - threshold high byte holds debounce mode bit 7 and threshold bits 14:8
// - below threshold the debounce count decrements, or clears in mode one
// - event when distance exceeds threshold longer than the debounce count
// - debounce period is the count times one sample period
module mvcd_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire mvcd_pkg::mvcd_regreq_s reg_req_in,
   input wire logic sample_valid_in,
   input wire mvcd_pkg::mvcd_vec_s sample_in,
   output logic [7:0] reg_rdata_out,
   output logic vector_change_flag_out,
   output logic wake_activity_out,
   output logic interrupt_pin_one_out,
   output logic interrupt_pin_two_out
);
   logic [7:0] cfg_reg;
   logic [7:0] ths_high_reg;
   logic [7:0] ths_low_reg;
   logic [7:0] cnt_cfg_reg;
   mvcd_pkg::mvcd_vec_s init_reg;
   mvcd_pkg::mvcd_vec_s ref_reg;
   mvcd_pkg::mvcd_vec_s last_sample_reg;
   logic [7:0] dbcnt_reg;
   logic en_prev_reg;
   logic flag_reg;
   logic flag_next;
   logic above;
   logic event_hit;
   logic en_load;
   logic src_read;
   logic int_gate;

   // Squared Euclidean distance; no root needed, the threshold is squared instead
   function automatic logic [35:0] dist_sq(input mvcd_pkg::mvcd_vec_s a, input mvcd_pkg::mvcd_vec_s b);
      logic signed [16:0] dx;
      logic signed [16:0] dy;
      logic signed [16:0] dz;
      dx = 17'(a.x) - 17'(b.x);
      dy = 17'(a.y) - 17'(b.y);
      dz = 17'(a.z) - 17'(b.z);
      dist_sq = 36'(34'(dx * dx)) + 36'(34'(dy * dy)) + 36'(34'(dz * dz));
   endfunction

   // Byte write helper for the split initial-value registers
   function automatic logic [15:0] put_byte(input logic [15:0] old, input logic high, input logic [7:0] b);
      put_byte = high ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   logic wr_hit;
   assign wr_hit = reg_req_in.wr;
   assign en_load = cfg_reg[mvcd_pkg::CFG_EN_BIT] & ~en_prev_reg;
   assign src_read = reg_req_in.rd && (reg_req_in.addr == mvcd_pkg::INT_SRC_ADDR);

   // Configuration and threshold registers
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_reg <= mvcd_pkg::BYTE_RESET;
         ths_high_reg <= mvcd_pkg::BYTE_RESET;
         ths_low_reg <= mvcd_pkg::BYTE_RESET;
         cnt_cfg_reg <= mvcd_pkg::BYTE_RESET;
      end else if (wr_hit) begin
         unique case (reg_req_in.addr)
            mvcd_pkg::CFG_ADDR: cfg_reg <= reg_req_in.wdata;
            mvcd_pkg::THS_HIGH_ADDR: ths_high_reg <= reg_req_in.wdata;
            mvcd_pkg::THS_LOW_ADDR: ths_low_reg <= reg_req_in.wdata;
            mvcd_pkg::CNT_ADDR: cnt_cfg_reg <= reg_req_in.wdata;
            default: ;
         endcase
      end
   end

   // Initial-value registers, high byte at the lower offset
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         init_reg <= '{mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET};
      end else if (wr_hit) begin
         unique case (reg_req_in.addr)
            mvcd_pkg::INITX_HIGH_ADDR: init_reg.x <= put_byte(init_reg.x, 1'b1, reg_req_in.wdata);
            mvcd_pkg::INITX_LOW_ADDR: init_reg.x <= put_byte(init_reg.x, 1'b0, reg_req_in.wdata);
            mvcd_pkg::INITY_HIGH_ADDR: init_reg.y <= put_byte(init_reg.y, 1'b1, reg_req_in.wdata);
            mvcd_pkg::INITY_LOW_ADDR: init_reg.y <= put_byte(init_reg.y, 1'b0, reg_req_in.wdata);
            mvcd_pkg::INITZ_HIGH_ADDR: init_reg.z <= put_byte(init_reg.z, 1'b1, reg_req_in.wdata);
            mvcd_pkg::INITZ_LOW_ADDR: init_reg.z <= put_byte(init_reg.z, 1'b0, reg_req_in.wdata);
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the read strobe; unmapped offsets read zero
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= mvcd_pkg::BYTE_RESET;
      end else if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            mvcd_pkg::INT_SRC_ADDR: reg_rdata_out <= 8'(flag_reg) << mvcd_pkg::SRC_VEC_BIT;
            mvcd_pkg::CFG_ADDR: reg_rdata_out <= cfg_reg;
            mvcd_pkg::THS_HIGH_ADDR: reg_rdata_out <= ths_high_reg;
            mvcd_pkg::THS_LOW_ADDR: reg_rdata_out <= ths_low_reg;
            mvcd_pkg::CNT_ADDR: reg_rdata_out <= cnt_cfg_reg;
            mvcd_pkg::INITX_HIGH_ADDR: reg_rdata_out <= init_reg.x[15:8];
            mvcd_pkg::INITX_LOW_ADDR: reg_rdata_out <= init_reg.x[7:0];
            mvcd_pkg::INITY_HIGH_ADDR: reg_rdata_out <= init_reg.y[15:8];
            mvcd_pkg::INITY_LOW_ADDR: reg_rdata_out <= init_reg.y[7:0];
            mvcd_pkg::INITZ_HIGH_ADDR: reg_rdata_out <= init_reg.z[15:8];
            mvcd_pkg::INITZ_LOW_ADDR: reg_rdata_out <= init_reg.z[7:0];
            default: reg_rdata_out <= mvcd_pkg::BYTE_RESET;
         endcase
      end
   end

   // Keep the newest sample so an enable between samples has data to capture
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         last_sample_reg <= '{mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET};
      end else if (sample_valid_in) begin
         last_sample_reg <= sample_in;
      end
   end

   // Enable edge tracking
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         en_prev_reg <= 1'b0;
      end else begin
         en_prev_reg <= cfg_reg[mvcd_pkg::CFG_EN_BIT];
      end
   end

   // Threshold comparison, strictly greater; sample rate above 400 Hz is not guarded here
   assign above = dist_sq(sample_in, ref_reg) >
                  36'({ths_high_reg[mvcd_pkg::THS_HIGH_MSB:0], ths_low_reg} *
                      {ths_high_reg[mvcd_pkg::THS_HIGH_MSB:0], ths_low_reg});
   // Event once the excursion has outlasted the programmed count of samples
   assign event_hit = cfg_reg[mvcd_pkg::CFG_EN_BIT] & sample_valid_in & above & (dbcnt_reg >= cnt_cfg_reg);

   // Debounce counter, one step per delivered sample; hybrid halving shows up as a slower strobe
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dbcnt_reg <= mvcd_pkg::BYTE_RESET;
      end else if (!cfg_reg[mvcd_pkg::CFG_EN_BIT] || en_load) begin
         dbcnt_reg <= mvcd_pkg::BYTE_RESET;
      end else if (sample_valid_in) begin
         if (above) begin
            if (dbcnt_reg < cnt_cfg_reg) begin
               dbcnt_reg <= dbcnt_reg + 8'h01;
            end
         end else if (ths_high_reg[mvcd_pkg::THS_DBMODE_BIT]) begin
            dbcnt_reg <= mvcd_pkg::BYTE_RESET;
         end else if (dbcnt_reg != 8'h00) begin
            dbcnt_reg <= dbcnt_reg - 8'h01;
         end
      end
   end

   // Reference vector; held in the block only, never readable
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_reg <= '{mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET, mvcd_pkg::AXIS_RESET};
      end else if (en_load) begin
         if (cfg_reg[mvcd_pkg::CFG_INITM_BIT]) begin
            ref_reg <= init_reg;
         end else begin
            ref_reg <= last_sample_reg;
         end
      end else if (cfg_reg[mvcd_pkg::CFG_EN_BIT] && cfg_reg[mvcd_pkg::CFG_INITM_BIT] &&
                   cfg_reg[mvcd_pkg::CFG_UPDM_BIT]) begin
         ref_reg <= init_reg;
      end else if (event_hit && !cfg_reg[mvcd_pkg::CFG_UPDM_BIT]) begin
         ref_reg <= sample_in;
      end
      // Update mode one leaves the reference alone on an event
   end

   // Flag next value; in latch mode a new event beats a same-cycle source read
   always_comb begin
      if (cfg_reg[mvcd_pkg::CFG_LATCH_BIT]) begin
         flag_next = event_hit | (flag_reg & ~src_read);
      end else if (sample_valid_in) begin
         flag_next = event_hit;
      end else begin
         flag_next = flag_reg & cfg_reg[mvcd_pkg::CFG_EN_BIT];
      end
   end

   assign int_gate = flag_next & cfg_reg[mvcd_pkg::CFG_INT_EN_BIT];

   // Flag and its pin and wake copies, all from flops
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flag_reg <= 1'b0;
         vector_change_flag_out <= 1'b0;
         wake_activity_out <= 1'b0;
         interrupt_pin_one_out <= 1'b0;
         interrupt_pin_two_out <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         vector_change_flag_out <= flag_next;
         wake_activity_out <= flag_next & cfg_reg[mvcd_pkg::CFG_WAKE_BIT];
         interrupt_pin_one_out <= int_gate & cfg_reg[mvcd_pkg::CFG_ROUTE_BIT];
         interrupt_pin_two_out <= int_gate & ~cfg_reg[mvcd_pkg::CFG_ROUTE_BIT];
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_latch_holds_flag: assert property (
      (cfg_reg[mvcd_pkg::CFG_LATCH_BIT] && flag_reg && !src_read && $stable(cfg_reg)) |=> flag_reg)
      else $error("latched flag dropped without a source read");
   a_live_flag_follows: assert property (
      (!cfg_reg[mvcd_pkg::CFG_LATCH_BIT] && sample_valid_in) |=> (flag_reg == $past(event_hit)))
      else $error("unlatched flag does not follow detection");
   a_ref_from_sample: assert property (
      (en_load && !cfg_reg[mvcd_pkg::CFG_INITM_BIT]) |=> (ref_reg == $past(last_sample_reg)))
      else $error("reference not captured from sample at enable");
   a_ref_from_init: assert property (
      (en_load && cfg_reg[mvcd_pkg::CFG_INITM_BIT]) |=> (ref_reg == $past(init_reg)))
      else $error("reference not loaded from initial values");
   a_ref_event_update: assert property (
      (event_hit && !en_load && !cfg_reg[mvcd_pkg::CFG_UPDM_BIT]) |=> (ref_reg == $past(sample_in)))
      else $error("reference not replaced on event");
   a_ref_kept_event: assert property (
      (event_hit && !en_load && cfg_reg[mvcd_pkg::CFG_UPDM_BIT] && !cfg_reg[mvcd_pkg::CFG_INITM_BIT])
      |=> $stable(ref_reg))
      else $error("reference changed in no-update mode");
   a_ref_live_init: assert property (
      (cfg_reg[mvcd_pkg::CFG_EN_BIT] && cfg_reg[mvcd_pkg::CFG_INITM_BIT] && cfg_reg[mvcd_pkg::CFG_UPDM_BIT])
      |=> (ref_reg == $past(init_reg)))
      else $error("initial values not live as reference");
   a_disabled_no_event: assert property (
      !cfg_reg[mvcd_pkg::CFG_EN_BIT] |-> (!event_hit && dbcnt_reg == 8'h00) or $fell(cfg_reg[mvcd_pkg::CFG_EN_BIT]))
      else $error("detection active while disabled");
   a_wake_gated: assert property (
      wake_activity_out |-> (vector_change_flag_out && $past(cfg_reg[mvcd_pkg::CFG_WAKE_BIT])))
      else $error("wake activity without flag and wake enable");
   a_pin_routing: assert property (
      !(interrupt_pin_one_out && interrupt_pin_two_out))
      else $error("both interrupt pins asserted");
   a_pin_source: assert property (
      (interrupt_pin_one_out || interrupt_pin_two_out) |->
      (vector_change_flag_out && $past(cfg_reg[mvcd_pkg::CFG_INT_EN_BIT])))
      else $error("interrupt pin without flag and enable");
   a_debounce_clear: assert property (
      (sample_valid_in && !above && ths_high_reg[mvcd_pkg::THS_DBMODE_BIT] && !en_load) |=> (dbcnt_reg == 8'h00))
      else $error("debounce counter not cleared below threshold");
   a_debounce_step: assert property (
      (sample_valid_in && !above && !ths_high_reg[mvcd_pkg::THS_DBMODE_BIT] && cfg_reg[mvcd_pkg::CFG_EN_BIT] &&
       !en_load && dbcnt_reg != 8'h00) |=> (dbcnt_reg == $past(dbcnt_reg) - 8'h01))
      else $error("debounce counter did not step down by one");
   a_event_needs_count: assert property (
      event_hit |-> (above && dbcnt_reg >= cnt_cfg_reg))
      else $error("event before debounce count reached");
   // Read clearing, refusals, routing, count step-up and register writes, judged one cycle after the cause
   a_src_read_clears: assert property (
      (cfg_reg[mvcd_pkg::CFG_LATCH_BIT] && src_read && !event_hit) |=> !flag_reg)
      else $error("source read did not clear latched flag");
   a_unlatched_off: assert property (
      (!cfg_reg[mvcd_pkg::CFG_LATCH_BIT] && !cfg_reg[mvcd_pkg::CFG_EN_BIT]) |=> !flag_reg)
      else $error("unlatched flag kept while disabled");
   a_ref_idle_off: assert property (
      !cfg_reg[mvcd_pkg::CFG_EN_BIT] |=> $stable(ref_reg))
      else $error("reference moved while disabled");
   a_int_blocked: assert property (
      !cfg_reg[mvcd_pkg::CFG_INT_EN_BIT] |=> !(interrupt_pin_one_out || interrupt_pin_two_out))
      else $error("interrupt pin driven while interrupt disabled");
   a_wake_blocked: assert property (
      !cfg_reg[mvcd_pkg::CFG_WAKE_BIT] |=> !wake_activity_out)
      else $error("wake activity while wake disabled");
   a_route_pin_one: assert property (
      interrupt_pin_one_out |-> $past(cfg_reg[mvcd_pkg::CFG_ROUTE_BIT]))
      else $error("pin one used with routing bit clear");
   a_route_pin_two: assert property (
      interrupt_pin_two_out |-> !$past(cfg_reg[mvcd_pkg::CFG_ROUTE_BIT]))
      else $error("pin two used with routing bit set");
   a_count_step_up: assert property (
      (sample_valid_in && above && cfg_reg[mvcd_pkg::CFG_EN_BIT] && !en_load && dbcnt_reg < cnt_cfg_reg)
      |=> (dbcnt_reg == $past(dbcnt_reg) + 8'h01))
      else $error("debounce counter did not step up by one");
   a_ths_high_write: assert property (
      (reg_req_in.wr && reg_req_in.addr == mvcd_pkg::THS_HIGH_ADDR)
      |=> (ths_high_reg == $past(reg_req_in.wdata)))
      else $error("threshold high byte write lost");
   a_init_byte_write: assert property (
      (reg_req_in.wr && reg_req_in.addr == mvcd_pkg::INITX_HIGH_ADDR)
      |=> (init_reg.x[15:8] == $past(reg_req_in.wdata)))
      else $error("initial value byte write lost");

   c_event_seen: cover property (event_hit);
   c_latched_read: cover property (flag_reg && cfg_reg[mvcd_pkg::CFG_LATCH_BIT] ##1 src_read);
   c_pin_one: cover property (interrupt_pin_one_out);
   c_pin_two: cover property (interrupt_pin_two_out);
   c_debounce_clear: cover property (sample_valid_in && !above && ths_high_reg[mvcd_pkg::THS_DBMODE_BIT] && dbcnt_reg != 8'h00);
endmodule

// ---- src/mvcd_pkg.sv ----
package mvcd_pkg;
   // Register offsets in the sensor register space
   localparam logic [7:0] INT_SRC_ADDR = 8'h5E;
   localparam logic [7:0] CFG_ADDR = 8'h69;
   localparam logic [7:0] THS_HIGH_ADDR = 8'h6A;
   localparam logic [7:0] THS_LOW_ADDR = 8'h6B;
   localparam logic [7:0] CNT_ADDR = 8'h6C;
   localparam logic [7:0] INITX_HIGH_ADDR = 8'h6D;
   localparam logic [7:0] INITX_LOW_ADDR = 8'h6E;
   localparam logic [7:0] INITY_HIGH_ADDR = 8'h6F;
   localparam logic [7:0] INITY_LOW_ADDR = 8'h70;
   localparam logic [7:0] INITZ_HIGH_ADDR = 8'h71;
   localparam logic [7:0] INITZ_LOW_ADDR = 8'h72;
   // Configuration field positions
   localparam int CFG_LATCH_BIT = 6;
   localparam int CFG_INITM_BIT = 5;
   localparam int CFG_UPDM_BIT = 4;
   localparam int CFG_EN_BIT = 3;
   localparam int CFG_WAKE_BIT = 2;
   localparam int CFG_INT_EN_BIT = 1;
   localparam int CFG_ROUTE_BIT = 0;
   // Threshold high byte fields
   localparam int THS_DBMODE_BIT = 7;
   localparam int THS_HIGH_MSB = 6;
   // Source register flag position
   localparam int SRC_VEC_BIT = 1;
   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] AXIS_RESET = 16'h0000;

   // One magnetic output sample
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } mvcd_vec_s;

   // Register access strobes from the serial interface decoder
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mvcd_regreq_s;
endpackage

// ---- test/mvcd_host_model.sv ----
`timescale 1ns/100ps
// Stand-in for the serial decoder and the magnetometer front end
module mvcd_host_model (
   input wire logic core_clk_in,
   input wire logic [7:0] reg_rdata_in,
   output mvcd_pkg::mvcd_regreq_s reg_req_out,
   output logic sample_valid_out,
   output mvcd_pkg::mvcd_vec_s sample_out
);
   logic [7:0] rd_data;
   initial begin
      reg_req_out = '0;
      sample_valid_out = 1'b0;
      sample_out = '0;
      rd_data = 8'h00;
   end
   // One access per call; strobe stands over exactly one taken edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk_in);
      #1;
      reg_req_out = {wr, !wr, addr, data};
      @(posedge core_clk_in);
      #1;
      reg_req_out.wr = 1'b0;
      reg_req_out.rd = 1'b0;
      // Read data is registered, so it is taken one edge later
      @(posedge core_clk_in);
      #1;
      rd_data = reg_rdata_in;
   endtask
   // Samples come no closer than one per sample period
   task automatic send(input logic signed [15:0] x);
      @(posedge core_clk_in);
      #1;
      sample_valid_out = 1'b1;
      sample_out = {x, 16'h0000, 16'h0000};
      @(posedge core_clk_in);
      #1;
      sample_valid_out = 1'b0;
      // Stale data is scrambled so nothing can lean on it outside the strobe
      sample_out = ~sample_out;
      @(posedge core_clk_in);
      #1;
   endtask
endmodule

// ---- test/tb_magnetic_vector_change_detector.sv ----
`timescale 1ns/100ps
// Register and sample sequences against the vector change detector
module tb_magnetic_vector_change_detector;
   logic core_clk_in;
   logic rst_in;
   mvcd_pkg::mvcd_regreq_s reg_req;
   logic sample_valid;
   mvcd_pkg::mvcd_vec_s sample;
   logic [7:0] rdata;
   logic flag;
   logic wake;
   logic pin_one;
   logic pin_two;
   int mismatches;
   int total_checks;

   mvcd_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_req_in(reg_req), .sample_valid_in(sample_valid),
      .sample_in(sample), .reg_rdata_out(rdata), .vector_change_flag_out(flag), .wake_activity_out(wake),
      .interrupt_pin_one_out(pin_one), .interrupt_pin_two_out(pin_two));
   mvcd_host_model host (.core_clk_in(core_clk_in), .reg_rdata_in(rdata), .reg_req_out(reg_req),
      .sample_valid_out(sample_valid), .sample_out(sample));

   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
      host.access(1'b0, a, 8'h00);
      check(name, host.rd_data, e);
   endtask
   // Outputs are compared packed as flag, wake, pin one, pin two
   task automatic smp_chk(input string name, input logic signed [15:0] x, input logic [3:0] e);
      host.send(x);
      check(name, {4'h0, flag, wake, pin_one, pin_two}, {4'h0, e});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Whole run needs under two hundred cycles; this bound only catches a hang
   initial begin
      #200000;
      mismatches++;
      $display("watchdog expired");
      final_report();
   end

   initial begin
      mismatches = 0;
      total_checks = 0;
      rst_in = 1'b1;
      repeat (16) @(posedge core_clk_in);
      #1;
      rst_in = 1'b0;
      check("outputs after reset", {4'h0, flag, wake, pin_one, pin_two}, 8'h00);
      rd_chk("config reset", 8'h69, 8'h00);
      rd_chk("threshold high reset", 8'h6A, 8'h00);
      rd_chk("source reset", 8'h5E, 8'h00);
      wr(8'h6A, 8'hFF);
      rd_chk("threshold high all ones", 8'h6A, 8'hFF);
      wr(8'h6A, 8'h00);
      wr(8'h80, 8'h55);
      rd_chk("unmapped read", 8'h80, 8'h00);
      wr(8'h6B, 8'h0A);
      rd_chk("threshold low", 8'h6B, 8'h0A);
      $display("test registers done");
      // Latched, reference from zero initial values, routed to pin one
      wr(8'h69, 8'h7F);
      rd_chk("config readback", 8'h69, 8'h7F);
      smp_chk("latched event", 16'h0064, 4'b1110);
      smp_chk("latched hold", 16'h0000, 4'b1110);
      rd_chk("source flag", 8'h5E, 8'h02);
      check("cleared by read", {4'h0, flag, wake, pin_one, pin_two}, 8'h00);
      $display("test latch done");
      // Unlatched, reference from the last sample, routed to pin two
      wr(8'h69, 8'h00);
      smp_chk("disabled", 16'h01F4, 4'b0000);
      smp_chk("disabled again", 16'h0032, 4'b0000);
      wr(8'h69, 8'h0A);
      smp_chk("near captured ref", 16'h0037, 4'b0000);
      smp_chk("event pin two", 16'h0064, 4'b1001);
      smp_chk("ref moved", 16'h0069, 4'b0000);
      $display("test unlatched done");
      // Reference frozen on events, then interrupt gated off
      wr(8'h69, 8'h1A);
      smp_chk("frozen first", 16'h00C8, 4'b1001);
      smp_chk("frozen second", 16'h00CD, 4'b1001);
      wr(8'h69, 8'h18);
      smp_chk("interrupt gated", 16'h012C, 4'b1000);
      $display("test update mode done");
      // Initial-value writes act as live reference
      wr(8'h69, 8'h00);
      wr(8'h69, 8'h3A);
      wr(8'h6D, 8'h01);
      rd_chk("initial x high", 8'h6D, 8'h01);
      smp_chk("live ref match", 16'h0100, 4'b0000);
      wr(8'h6D, 8'h00);
      smp_chk("live ref cleared", 16'h0100, 4'b1001);
      $display("test live reference done");
      // Debounce of two samples, decrement then clear mode
      wr(8'h6C, 8'h02);
      rd_chk("debounce count", 8'h6C, 8'h02);
      wr(8'h69, 8'h00);
      wr(8'h69, 8'h3A);
      smp_chk("debounce one", 16'h0064, 4'b0000);
      smp_chk("debounce two", 16'h0064, 4'b0000);
      smp_chk("debounce fire", 16'h0064, 4'b1001);
      smp_chk("below", 16'h0000, 4'b0000);
      smp_chk("decrement refill", 16'h0064, 4'b0000);
      smp_chk("decrement fire", 16'h0064, 4'b1001);
      wr(8'h6A, 8'h80);
      smp_chk("clear below", 16'h0000, 4'b0000);
      smp_chk("clear one", 16'h0064, 4'b0000);
      smp_chk("clear two", 16'h0064, 4'b0000);
      smp_chk("clear fire", 16'h0064, 4'b1001);
      // Upper threshold bits raise the bar to 266 with no debounce
      wr(8'h6C, 8'h00);
      wr(8'h6A, 8'h81);
      smp_chk("high threshold under", 16'h00C8, 4'b0000);
      smp_chk("high threshold over", 16'h0190, 4'b1001);
      $display("test debounce done");
      final_report();
   end
endmodule
